//--- common/daf_pkg.sv
// Shared constants and types of the diagnostic alarm and warning flag block
package daf_pkg;

  // Two-wire bus slave address of the diagnostic page (A2h as 8-bit form)
  localparam logic [6:0] DEV_ADDR        = 7'h51;

  // Register byte addresses on the diagnostic page
  localparam logic [7:0] OFS_ALARM_PRI   = 8'h70;
  localparam logic [7:0] OFS_ALARM_RX    = 8'h71;
  localparam logic [7:0] OFS_WARN_PRI    = 8'h74;

  // Reset values, the reserved receive bits and the answer for unmapped bytes
  localparam logic [7:0] RST_FLAGS       = 8'h00;
  localparam logic [7:0] RD_UNMAPPED     = 8'h00;
  localparam logic [5:0] RX_RSVD_VAL     = 6'h00;

  // Flag bit positions of the primary alarm and warning bytes, then of the receive alarm byte
  localparam int BIT_TEMP_HI  = 7;
  localparam int BIT_TEMP_LO  = 6;
  localparam int BIT_VOLT_HI  = 5;
  localparam int BIT_VOLT_LO  = 4;
  localparam int BIT_BIAS_HI  = 3;
  localparam int BIT_BIAS_LO  = 2;
  localparam int BIT_TXP_HI   = 1;
  localparam int BIT_TXP_LO   = 0;
  localparam int BIT_RX_OVL   = 7;
  localparam int BIT_RX_LOSS  = 6;

  // Comparator slots: five alarm pairs, then four warning pairs
  localparam int NUM_CMP      = 9;
  localparam int CMP_TEMP_A   = 0;
  localparam int CMP_VOLT_A   = 1;
  localparam int CMP_BIAS_A   = 2;
  localparam int CMP_TXP_A    = 3;
  localparam int CMP_RXP_A    = 4;
  localparam int CMP_TEMP_W   = 5;
  localparam int CMP_VOLT_W   = 6;
  localparam int CMP_BIAS_W   = 7;
  localparam int CMP_TXP_W    = 8;

  // Bit counter figures of the serial slave
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT   = 4'h7;

  // Serial slave states, Gray coded along the usual path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h3,
    ST_PTR  = 4'h2,
    ST_PACK = 4'h6,
    ST_WDAT = 4'h7,
    ST_WACK = 4'h5,
    ST_RDAT = 4'h4,
    ST_RACK = 4'hc
  } daf_state_t;

endpackage

//--- src/daf_pin_sync.sv
// Three-stage pin synchroniser with an agreement filter
`timescale 1ns/1ps
module daf_pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // First stage only feeds the second; the filter looks at stages two and three
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_r    <= RST_VAL;
      s2_r    <= RST_VAL;
      s3_r    <= RST_VAL;
      level_r <= RST_VAL;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_r <= s3_r;  // Change counts once two stages agree
    end
  end

  assign level_out = level_r;

endmodule // daf_pin_sync

//--- src/daf_limit_cmp.sv
// Upper and lower limit comparator for one monitored byte
`timescale 1ns/1ps
module daf_limit_cmp #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] meas,
  input  wire logic [W-1:0] hi_lim,
  input  wire logic [W-1:0] lo_lim,
  output logic              above,
  output logic              below
);

  // Strict compares: a value equal to a limit is still in range
  assign above = (meas > hi_lim);
  assign below = (meas < lo_lim);

endmodule // daf_limit_cmp

//--- src/daf_flags_top.sv
// Alarm and warning flag registers with two-wire serial read access
//
// Contract
// [RULE1] Temperature above alarm high sets alarm bit 7
// [RULE2] Temperature below alarm low sets alarm bit 6
// [RULE3] Voltage above alarm high sets alarm bit 5
// [RULE4] Voltage below alarm low sets alarm bit 4
// [RULE5] Bias above alarm high sets alarm bit 3
// [RULE6] Bias below alarm low sets alarm bit 2
// [RULE7] Transmit power above alarm high sets bit 1
// [RULE8] Transmit power below alarm low sets bit 0
// [RULE9] Receive power above high sets overload bit
// [RULE10] Receive power below low sets loss bit
// [RULE11] Host writes zeros to receive reserved bits
// [RULE12] Flag reads one on condition, else zero
// [RULE13] Flags reset zero, update after first conversion
// [RULE14] Temperature above warning high sets bit 7
// [RULE15] Temperature below warning low sets bit 6
// [RULE16] Voltage above warning high sets bit 5
// [RULE17] Voltage below warning low sets bit 4
// [RULE18] Bias above warning high sets bit 3
// [RULE19] Bias below warning low sets bit 2
// [RULE20] Transmit power above warning high sets bit 1
// [RULE21] Transmit power below warning low sets bit 0
// [RULE22] Compares use upper measurement bytes only
// [RULE23] Flags track each conversion, reads never clear
`timescale 1ns/1ps
module daf_flags_top #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // Two-wire serial pins
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  // Conversion complete strobe, one cycle, same clock
  input  wire logic         conv_done,
  // Upper measurement bytes
  input  wire logic [W-1:0] temperature_upper_byte,
  input  wire logic [W-1:0] supply_voltage_upper_byte,
  input  wire logic [W-1:0] laser_current_upper_byte,
  input  wire logic [W-1:0] transmit_power_upper_byte,
  input  wire logic [W-1:0] receive_power_upper_byte,
  // Alarm limits
  input  wire logic [W-1:0] temperature_alarm_upper_limit,
  input  wire logic [W-1:0] temperature_alarm_lower_limit,
  input  wire logic [W-1:0] voltage_alarm_upper_limit,
  input  wire logic [W-1:0] voltage_alarm_lower_limit,
  input  wire logic [W-1:0] current_alarm_upper_limit,
  input  wire logic [W-1:0] current_alarm_lower_limit,
  input  wire logic [W-1:0] transmit_power_alarm_upper_limit,
  input  wire logic [W-1:0] transmit_power_alarm_lower_limit,
  input  wire logic [W-1:0] receive_power_alarm_upper_limit,
  input  wire logic [W-1:0] receive_power_alarm_lower_limit,
  // Warning limits
  input  wire logic [W-1:0] temperature_warn_upper_limit,
  input  wire logic [W-1:0] temperature_warn_lower_limit,
  input  wire logic [W-1:0] voltage_warn_upper_limit,
  input  wire logic [W-1:0] voltage_warn_lower_limit,
  input  wire logic [W-1:0] current_warn_upper_limit,
  input  wire logic [W-1:0] current_warn_lower_limit,
  input  wire logic [W-1:0] transmit_power_warn_upper_limit,
  input  wire logic [W-1:0] transmit_power_warn_lower_limit,
  // Flag register images
  output logic [7:0]        alarm_flags_primary,
  output logic [7:0]        alarm_flags_receive,
  output logic [7:0]        warning_flags_primary
);

  ////////////////////////////////////////////////////////////////////////////
  // Limit comparators

  logic [W-1:0] cmp_meas [daf_pkg::NUM_CMP];
  logic [W-1:0] cmp_hi   [daf_pkg::NUM_CMP];
  logic [W-1:0] cmp_lo   [daf_pkg::NUM_CMP];
  logic [daf_pkg::NUM_CMP-1:0] cmp_above;
  logic [daf_pkg::NUM_CMP-1:0] cmp_below;

  // Only the upper bytes reach the comparators; low bytes never matter
  assign cmp_meas[daf_pkg::CMP_TEMP_A] = temperature_upper_byte;     // RULE22
  assign cmp_meas[daf_pkg::CMP_VOLT_A] = supply_voltage_upper_byte;  // RULE22
  assign cmp_meas[daf_pkg::CMP_BIAS_A] = laser_current_upper_byte;   // RULE22
  assign cmp_meas[daf_pkg::CMP_TXP_A]  = transmit_power_upper_byte;  // RULE22
  assign cmp_meas[daf_pkg::CMP_RXP_A]  = receive_power_upper_byte;   // RULE22
  assign cmp_meas[daf_pkg::CMP_TEMP_W] = temperature_upper_byte;
  assign cmp_meas[daf_pkg::CMP_VOLT_W] = supply_voltage_upper_byte;
  assign cmp_meas[daf_pkg::CMP_BIAS_W] = laser_current_upper_byte;
  assign cmp_meas[daf_pkg::CMP_TXP_W]  = transmit_power_upper_byte;

  // Upper limits per slot
  assign cmp_hi[daf_pkg::CMP_TEMP_A] = temperature_alarm_upper_limit;
  assign cmp_hi[daf_pkg::CMP_VOLT_A] = voltage_alarm_upper_limit;
  assign cmp_hi[daf_pkg::CMP_BIAS_A] = current_alarm_upper_limit;
  assign cmp_hi[daf_pkg::CMP_TXP_A]  = transmit_power_alarm_upper_limit;
  assign cmp_hi[daf_pkg::CMP_RXP_A]  = receive_power_alarm_upper_limit;
  assign cmp_hi[daf_pkg::CMP_TEMP_W] = temperature_warn_upper_limit;
  assign cmp_hi[daf_pkg::CMP_VOLT_W] = voltage_warn_upper_limit;
  assign cmp_hi[daf_pkg::CMP_BIAS_W] = current_warn_upper_limit;
  assign cmp_hi[daf_pkg::CMP_TXP_W]  = transmit_power_warn_upper_limit;

  // Lower limits per slot
  assign cmp_lo[daf_pkg::CMP_TEMP_A] = temperature_alarm_lower_limit;
  assign cmp_lo[daf_pkg::CMP_VOLT_A] = voltage_alarm_lower_limit;
  assign cmp_lo[daf_pkg::CMP_BIAS_A] = current_alarm_lower_limit;
  assign cmp_lo[daf_pkg::CMP_TXP_A]  = transmit_power_alarm_lower_limit;
  assign cmp_lo[daf_pkg::CMP_RXP_A]  = receive_power_alarm_lower_limit;
  assign cmp_lo[daf_pkg::CMP_TEMP_W] = temperature_warn_lower_limit;
  assign cmp_lo[daf_pkg::CMP_VOLT_W] = voltage_warn_lower_limit;
  assign cmp_lo[daf_pkg::CMP_BIAS_W] = current_warn_lower_limit;
  assign cmp_lo[daf_pkg::CMP_TXP_W]  = transmit_power_warn_lower_limit;

  // One comparator pair per monitored slot
  genvar gi;
  generate
    for (gi = 0; gi < daf_pkg::NUM_CMP; gi++)
    begin : g_cmp
      daf_limit_cmp #(
        .W (W)
      ) u_cmp (
        .meas   (cmp_meas[gi]),
        .hi_lim (cmp_hi[gi]),
        .lo_lim (cmp_lo[gi]),
        .above  (cmp_above[gi]),
        .below  (cmp_below[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Flag registers

  logic [7:0] alarm_pri_r;
  logic [7:0] alarm_rx_r;
  logic [7:0] warn_pri_r;
  logic [7:0] alarm_pri_nxt;
  logic [7:0] alarm_rx_nxt;
  logic [7:0] warn_pri_nxt;

  // Primary alarm byte: one when the condition holds, zero otherwise
  assign alarm_pri_nxt[daf_pkg::BIT_TEMP_HI] =
    cmp_above[daf_pkg::CMP_TEMP_A];  // RULE1
  assign alarm_pri_nxt[daf_pkg::BIT_TEMP_LO] =
    cmp_below[daf_pkg::CMP_TEMP_A];  // RULE2
  assign alarm_pri_nxt[daf_pkg::BIT_VOLT_HI] =
    cmp_above[daf_pkg::CMP_VOLT_A];  // RULE3
  assign alarm_pri_nxt[daf_pkg::BIT_VOLT_LO] =
    cmp_below[daf_pkg::CMP_VOLT_A];  // RULE4
  assign alarm_pri_nxt[daf_pkg::BIT_BIAS_HI] =
    cmp_above[daf_pkg::CMP_BIAS_A];  // RULE5
  assign alarm_pri_nxt[daf_pkg::BIT_BIAS_LO] =
    cmp_below[daf_pkg::CMP_BIAS_A];  // RULE6
  assign alarm_pri_nxt[daf_pkg::BIT_TXP_HI] =
    cmp_above[daf_pkg::CMP_TXP_A];   // RULE7
  assign alarm_pri_nxt[daf_pkg::BIT_TXP_LO] =
    cmp_below[daf_pkg::CMP_TXP_A];   // RULE8

  // Receive alarm byte; the reserved low bits are never set here
  assign alarm_rx_nxt = {cmp_above[daf_pkg::CMP_RXP_A],  // RULE9
                         cmp_below[daf_pkg::CMP_RXP_A],  // RULE10
                         daf_pkg::RX_RSVD_VAL};          // RULE11

  // Warning byte shares the alarm bit layout
  assign warn_pri_nxt[daf_pkg::BIT_TEMP_HI] =
    cmp_above[daf_pkg::CMP_TEMP_W];  // RULE14
  assign warn_pri_nxt[daf_pkg::BIT_TEMP_LO] =
    cmp_below[daf_pkg::CMP_TEMP_W];  // RULE15
  assign warn_pri_nxt[daf_pkg::BIT_VOLT_HI] =
    cmp_above[daf_pkg::CMP_VOLT_W];  // RULE16
  assign warn_pri_nxt[daf_pkg::BIT_VOLT_LO] =
    cmp_below[daf_pkg::CMP_VOLT_W];  // RULE17
  assign warn_pri_nxt[daf_pkg::BIT_BIAS_HI] =
    cmp_above[daf_pkg::CMP_BIAS_W];  // RULE18
  assign warn_pri_nxt[daf_pkg::BIT_BIAS_LO] =
    cmp_below[daf_pkg::CMP_BIAS_W];  // RULE19
  assign warn_pri_nxt[daf_pkg::BIT_TXP_HI] =
    cmp_above[daf_pkg::CMP_TXP_W];   // RULE20
  assign warn_pri_nxt[daf_pkg::BIT_TXP_LO] =
    cmp_below[daf_pkg::CMP_TXP_W];   // RULE21

  // Load only on a finished conversion, so limits rewritten mid-cycle
  // cannot glitch a flag; serial reads leave them untouched
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      alarm_pri_r <= daf_pkg::RST_FLAGS;  // RULE13
      alarm_rx_r  <= daf_pkg::RST_FLAGS;  // RULE13
      warn_pri_r  <= daf_pkg::RST_FLAGS;  // RULE13
    end
    else if (conv_done)
    begin
      alarm_pri_r <= alarm_pri_nxt;  // RULE12 RULE23
      alarm_rx_r  <= alarm_rx_nxt;   // RULE12 RULE23
      warn_pri_r  <= warn_pri_nxt;   // RULE12 RULE23
    end
  end

  assign alarm_flags_primary   = alarm_pri_r;
  assign alarm_flags_receive   = alarm_rx_r;
  assign warning_flags_primary = warn_pri_r;

  ////////////////////////////////////////////////////////////////////////////
  // Serial pin conditioning and bus events

  logic scl_f;
  logic sda_f;
  logic scl_d_r;
  logic sda_d_r;

  daf_pin_sync #(
    .RST_VAL (1'b1)
  ) u_sync_scl (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .pin_in    (scl_in),
    .level_out (scl_f)
  );

  daf_pin_sync #(
    .RST_VAL (1'b1)
  ) u_sync_sda (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .pin_in    (sda_in),
    .level_out (sda_f)
  );

  // Previous filtered levels for edge detection
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end
  end

  // Start and stop are data edges while the clock stays high
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise  = scl_f & ~scl_d_r;
  assign scl_fall  = ~scl_f & scl_d_r;
  assign bus_start = scl_f & scl_d_r & sda_d_r & ~sda_f;
  assign bus_stop  = scl_f & scl_d_r & ~sda_d_r & sda_f;

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection

  logic [7:0] ptr_r;
  logic [7:0] rd_byte;
  logic       hit_pri;
  logic       hit_rx;
  logic       hit_warn;
  assign hit_pri  = (ptr_r == daf_pkg::OFS_ALARM_PRI);
  assign hit_rx   = (ptr_r == daf_pkg::OFS_ALARM_RX);
  assign hit_warn = (ptr_r == daf_pkg::OFS_WARN_PRI);
  // Unmapped bytes answer zero rather than stalling the bus
  assign rd_byte  = hit_pri  ? alarm_pri_r :
                    hit_rx   ? alarm_rx_r  :
                    hit_warn ? warn_pri_r  : daf_pkg::RD_UNMAPPED;

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave state machine

  daf_pkg::daf_state_t state_r;
  daf_pkg::daf_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] ptr_nxt;
  logic       rw_r;
  logic       rw_nxt;
  logic       mack_r;
  logic       mack_nxt;
  logic       oe_r;
  logic       oe_nxt;
  logic       addr_hit;
  assign addr_hit = (shift_r[7:1] == daf_pkg::DEV_ADDR);

  // Data is sampled on clock rise and driven on clock fall; no stretching
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt   = ptr_r;
    rw_nxt    = rw_r;
    mack_nxt  = mack_r;
    oe_nxt    = oe_r;
    if (bus_start)
    begin
      state_nxt = daf_pkg::ST_ADDR;
      cnt_nxt   = 4'h0;
      oe_nxt    = 1'b0;
    end
    else if (bus_stop)
    begin
      state_nxt = daf_pkg::ST_IDLE;
      oe_nxt    = 1'b0;
    end
    else if (scl_rise)
    begin
      case (state_r)
        daf_pkg::ST_ADDR, daf_pkg::ST_PTR, daf_pkg::ST_WDAT:
        begin
          shift_nxt = {shift_r[6:0], sda_f};
          cnt_nxt   = cnt_r + 4'h1;
        end
        daf_pkg::ST_RACK: mack_nxt = sda_f;
        default:          mack_nxt = mack_r;
      endcase
    end
    else if (scl_fall)
    begin
      case (state_r)
        daf_pkg::ST_ADDR:
          if (cnt_r == daf_pkg::BITS_PER_BYTE)
          begin
            state_nxt = addr_hit ? daf_pkg::ST_AACK : daf_pkg::ST_IDLE;
            oe_nxt    = addr_hit;
            rw_nxt    = shift_r[0];
          end
        daf_pkg::ST_AACK:
          if (rw_r)
          begin
            state_nxt = daf_pkg::ST_RDAT;
            shift_nxt = rd_byte;
            oe_nxt    = ~rd_byte[7];
            ptr_nxt   = ptr_r + 8'h01;
            cnt_nxt   = 4'h0;
          end
          else
          begin
            state_nxt = daf_pkg::ST_PTR;
            oe_nxt    = 1'b0;
            cnt_nxt   = 4'h0;
          end
        daf_pkg::ST_PTR:
          if (cnt_r == daf_pkg::BITS_PER_BYTE)
          begin
            state_nxt = daf_pkg::ST_PACK;
            ptr_nxt   = shift_r;
            oe_nxt    = 1'b1;
          end
        daf_pkg::ST_PACK, daf_pkg::ST_WACK:
        begin
          state_nxt = daf_pkg::ST_WDAT;
          oe_nxt    = 1'b0;
          cnt_nxt   = 4'h0;
        end
        // Flag bytes are read-only: written data is acknowledged and dropped
        daf_pkg::ST_WDAT:
          if (cnt_r == daf_pkg::BITS_PER_BYTE)
          begin
            state_nxt = daf_pkg::ST_WACK;
            ptr_nxt   = ptr_r + 8'h01;
            oe_nxt    = 1'b1;
          end
        daf_pkg::ST_RDAT:
          if (cnt_r == daf_pkg::LAST_TX_BIT)
          begin
            state_nxt = daf_pkg::ST_RACK;
            oe_nxt    = 1'b0;
          end
          else
          begin
            shift_nxt = {shift_r[6:0], 1'b0};
            oe_nxt    = ~shift_r[6];
            cnt_nxt   = cnt_r + 4'h1;
          end
        daf_pkg::ST_RACK:
          if (!mack_r)
          begin
            state_nxt = daf_pkg::ST_RDAT;
            shift_nxt = rd_byte;
            oe_nxt    = ~rd_byte[7];
            ptr_nxt   = ptr_r + 8'h01;
            cnt_nxt   = 4'h0;
          end
          else
            state_nxt = daf_pkg::ST_IDLE;
        default: state_nxt = daf_pkg::ST_IDLE;
      endcase
    end
  end

  // Slave registers; the pointer survives between transfers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= daf_pkg::ST_IDLE;
      cnt_r   <= 4'h0;
      shift_r <= 8'h00;
      ptr_r   <= 8'h00;
      rw_r    <= 1'b0;
      mack_r  <= 1'b1;
      oe_r    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r   <= ptr_nxt;
      rw_r    <= rw_nxt;
      mack_r  <= mack_nxt;
      oe_r    <= oe_nxt;
    end
  end

  // Open drain: the data level is always low, only the enable moves
  logic sda_lo_r;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      sda_lo_r <= 1'b0;
    else
      sda_lo_r <= 1'b0;
  end

  assign sda_out = sda_lo_r;
  assign sda_oe  = oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // Remembers whether any conversion has finished since reset
  logic conv_seen_r;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      conv_seen_r <= 1'b0;
    else if (conv_done)
      conv_seen_r <= 1'b1;
  end

  sequence s_temp_hot;
    conv_done && (temperature_upper_byte > temperature_alarm_upper_limit);
  endsequence

  sequence s_rx_dark;
    conv_done && (receive_power_upper_byte < receive_power_alarm_lower_limit);
  endsequence

  a_flags_before_conv: // RULE13
    assert property (!conv_seen_r |-> (alarm_pri_r == 8'h00)
                     && (alarm_rx_r == 8'h00) && (warn_pri_r == 8'h00))
    else $error("flag set before first conversion");

  a_temp_hi_alarm: // RULE1
    assert property (s_temp_hot |=> alarm_flags_primary[7])
    else $error("high temperature alarm missing");

  a_temp_lo_alarm: // RULE2
    assert property (conv_done |=> alarm_flags_primary[6] ==
      $past(temperature_upper_byte < temperature_alarm_lower_limit))
    else $error("low temperature alarm wrong");

  a_volt_alarms: // RULE3 RULE4
    assert property (conv_done |=> alarm_flags_primary[5:4] ==
      {$past(supply_voltage_upper_byte > voltage_alarm_upper_limit),
       $past(supply_voltage_upper_byte < voltage_alarm_lower_limit)})
    else $error("voltage alarm bits wrong");

  a_bias_hi_alarm: // RULE5
    assert property (conv_done && (laser_current_upper_byte <=
      current_alarm_upper_limit) |=> !alarm_flags_primary[3])
    else $error("bias high alarm set in range");

  a_txp_lo_alarm: // RULE8
    assert property (conv_done |=> alarm_flags_primary[0] ==
      $past(transmit_power_upper_byte < transmit_power_alarm_lower_limit))
    else $error("transmit low alarm wrong");

  a_rx_loss_alarm: // RULE10
    assert property (s_rx_dark |=> alarm_flags_receive[6])
    else $error("receive loss alarm missing");

  a_rx_reserved_zero: // RULE11
    assert property (alarm_flags_receive[5:0] == 6'h00)
    else $error("receive reserved bit set");

  a_warn_temp_hi: // RULE14
    assert property (conv_done |=> warning_flags_primary[7] ==
      $past(temperature_upper_byte > temperature_warn_upper_limit))
    else $error("temperature warning wrong");

  a_warn_txp_hi: // RULE20
    assert property (conv_done |=> warning_flags_primary[1] ==
      $past(transmit_power_upper_byte > transmit_power_warn_upper_limit))
    else $error("transmit high warning wrong");

  a_flags_hold: // RULE23
    assert property (!conv_done |=> $stable(alarm_flags_primary)
      && $stable(warning_flags_primary) && $stable(alarm_flags_receive))
    else $error("flags moved without conversion");

  a_stop_idle:
    assert property (bus_stop && !bus_start |=> state_r == daf_pkg::ST_IDLE
                     && !sda_oe)
    else $error("stop did not release bus");

endmodule // daf_flags_top

//--- verification/daf_host_model.sv
// Behavioural two-wire host that reads diagnostic bytes
`timescale 1ns/1ps
module daf_host_model (
  input  wire logic clk_sys,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drv
);
  logic [7:0] nak_cnt = 8'h00;
  // Bus idles high from time zero
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  ////////////////////////////////////////
  // Phases of 10 cycles keep high, low and setup above 8 cycles
  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // SDA held 4 cycles past the fall so the filtered SCL sees it stable
  task automatic bt(input logic b, output logic r);
    sda_drv = b;
    w(10);
    scl = 1'b1;
    w(10);
    r = sda_wire;
    scl = 1'b0;
    w(4);
  endtask
  // Start, also used as repeated start
  task automatic st();
    sda_drv = 1'b1;
    w(10);
    scl = 1'b1;
    w(10);
    sda_drv = 1'b0;
    w(10);
    scl = 1'b0;
    w(4);
  endtask
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    if (r) nak_cnt++;
  endtask
  // Stop: data rises while the clock is high
  task automatic sp();
    sda_drv = 1'b0;
    w(10);
    scl = 1'b1;
    w(10);
    sda_drv = 1'b1;
    w(10);
  endtask
  // Callers send zeros in the reserved receive bits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    st();
    tx({daf_pkg::DEV_ADDR, 1'b0});
    tx(a);
    tx(d);
    sp();
  endtask
  // Reads n bytes from a, first byte low; ack all but the last byte
  task automatic rd(input logic [7:0] a, input int n,
                    output logic [15:0] d);
    logic r;
    d = 16'h0000;
    st();
    tx({daf_pkg::DEV_ADDR, 1'b0});
    tx(a);
    st();
    tx({daf_pkg::DEV_ADDR, 1'b1});
    for (int j = 0; j < n; j++)
    begin
      for (int i = 7; i >= 0; i--) bt(1'b1, d[8*j+i]);
      bt(j == n - 1, r);
    end
    sp();
  endtask
endmodule // daf_host_model

//--- verification/daf_flags_tb.sv
// Self-checking bench of the alarm and warning flag block
`timescale 1ns/1ps
module daf_flags_tb;
  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic       conv_done = 1'b0;
  logic [7:0] m [0:4];
  logic [7:0] al [0:9];
  logic [7:0] wl [0:7];
  logic [7:0] vals [0:6] = '{8'h80, 8'hd0, 8'hb0, 8'h30, 8'h50, 8'hc0, 8'h40};
  logic [7:0] af, ar, wf, ea, er, ew;
  logic [15:0] q;
  logic       scl, hsda, sda_out, sda_oe;
  // Open drain: the slave shows sda_out while enabled, else the pull-up
  wire        sda_w = hsda & (~sda_oe | sda_out);
  int         n_fail = 0;
  int         cmp_count = 0;
  always #4 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  daf_flags_top #(.W(8)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .conv_done(conv_done),
    .temperature_upper_byte(m[0]), .supply_voltage_upper_byte(m[1]),
    .laser_current_upper_byte(m[2]), .transmit_power_upper_byte(m[3]),
    .receive_power_upper_byte(m[4]),
    .temperature_alarm_upper_limit(al[0]),
    .temperature_alarm_lower_limit(al[1]),
    .voltage_alarm_upper_limit(al[2]), .voltage_alarm_lower_limit(al[3]),
    .current_alarm_upper_limit(al[4]), .current_alarm_lower_limit(al[5]),
    .transmit_power_alarm_upper_limit(al[6]),
    .transmit_power_alarm_lower_limit(al[7]),
    .receive_power_alarm_upper_limit(al[8]),
    .receive_power_alarm_lower_limit(al[9]),
    .temperature_warn_upper_limit(wl[0]),
    .temperature_warn_lower_limit(wl[1]),
    .voltage_warn_upper_limit(wl[2]), .voltage_warn_lower_limit(wl[3]),
    .current_warn_upper_limit(wl[4]), .current_warn_lower_limit(wl[5]),
    .transmit_power_warn_upper_limit(wl[6]),
    .transmit_power_warn_lower_limit(wl[7]),
    .alarm_flags_primary(af), .alarm_flags_receive(ar),
    .warning_flags_primary(wf));
  daf_host_model hst (.clk_sys(clk_sys), .sda_wire(sda_w), .scl(scl),
    .sda_drv(hsda));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Expected flags from strict compares, equal counts as in range
  task automatic calc();
    for (int i = 0; i < 4; i++)
    begin
      ea[7-2*i] = m[i] > al[2*i];
      ea[6-2*i] = m[i] < al[2*i+1];
      ew[7-2*i] = m[i] > wl[2*i];
      ew[6-2*i] = m[i] < wl[2*i+1];
    end
    er = {m[4] > al[8], m[4] < al[9], 6'h00};
  endtask
  task automatic pulse();
    @(negedge clk_sys);
    conv_done = 1'b1;
    @(negedge clk_sys);
    conv_done = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  // Bounded wait: the bus transfers need about 5740 cycles
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    end_sim();
  end
  initial
  begin
    for (int i = 0; i < 5; i++) al[2*i] = 8'hc0;
    for (int i = 0; i < 5; i++) al[2*i+1] = 8'h40;
    for (int i = 0; i < 4; i++) wl[2*i] = 8'ha0;
    for (int i = 0; i < 4; i++) wl[2*i+1] = 8'h60;
    foreach (m[i]) m[i] = 8'h80;
    repeat (10) @(negedge clk_sys);
    nrst = 1'b1;
    // Out of range but no conversion yet, so flags must stay clear
    foreach (m[i]) m[i] = 8'hd0;
    repeat (8) @(negedge clk_sys);
    chk(af, 8'h00);
    chk(ar, 8'h00);
    chk(wf, 8'h00);
    $display("test reset done");
    // Rotation gives every lane every case, alarm limit boundaries included
    for (int k = 0; k < 7; k++)
    begin
      foreach (m[i]) m[i] = vals[(k + i) % 7];
      calc();
      pulse();
      chk(af & 8'hf0, ea & 8'hf0);
      chk(af & 8'h0f, ea & 8'h0f);
      chk(ar, er);
      chk(wf & 8'hf0, ew & 8'hf0);
      chk(wf & 8'h0f, ew & 8'h0f);
    end
    $display("test lanes done");
    // New inputs without a conversion must not reach the flags
    foreach (m[i]) m[i] = 8'h80;
    hst.rd(8'h70, 1, q);
    chk(q[7:0], ea);
    hst.rd(8'h71, 1, q);
    chk(q[7:0], er);
    hst.rd(8'h74, 1, q);
    chk(q[7:0], ew);
    hst.rd(8'h72, 1, q);
    chk(q[7:0], 8'h00);
    // A written flag byte is dropped; a burst steps on to the next byte
    hst.wr(8'h71, 8'h00);
    hst.rd(8'h70, 2, q);
    chk(q[7:0], ea);
    chk(q[15:8], er);
    chk(hst.nak_cnt, 8'h00);
    $display("test bus done");
    // A second reset in mid-run clears every flag
    nrst = 1'b0;
    @(negedge clk_sys);
    chk(af | ar | wf, 8'h00);
    nrst = 1'b1;
    $display("test rereset done");
    end_sim();
  end
endmodule // daf_flags_tb
